/* File: verilog/dsr_pkg.sv */
// package: register map, field layout, codes and reset values of the drive setting readback block
package dsr_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_MODE     = 8'h08;
    localparam logic [7:0] OFS_RAM_FREQ = 8'h0C;
    localparam logic [7:0] OFS_EEP_FREQ = 8'h10;
    localparam logic [7:0] OFS_CFG      = 8'h14;

    // channel bit positions in ctrl (request) and status (done)
    localparam int CH_MODE = 0;
    localparam int CH_RAM  = 1;
    localparam int CH_EEP  = 2;
    localparam int CH_NUM  = 3;

    // cfg field positions
    localparam int CFG_UNIT_LSB = 0;
    localparam int CFG_MSEL_LSB = 4;

    // reset values
    localparam logic [2:0]  CTRL_RST = 3'h0;
    localparam logic [1:0]  UNIT_RST = 2'h0;
    localparam logic [3:0]  MSEL_RST = 4'h0;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // operation mode readback codes
    localparam logic [15:0] MODE_NET = 16'h0000;
    localparam logic [15:0] MODE_EXT = 16'h0001;
    localparam logic [15:0] MODE_PU  = 16'h0002;

    // mode selection parameter values that force the panel unit code
    localparam logic [3:0] MSEL_PU_A = 4'h3;
    localparam logic [3:0] MSEL_PU_B = 4'h4;

    // frequency readback unit select
    localparam logic [1:0] UNIT_HZ    = 2'h0;
    localparam logic [1:0] UNIT_RPM1  = 2'h1;
    localparam logic [1:0] UNIT_RPM01 = 2'h2;

    // rpm = f[0.01Hz] * 120 / (100 * poles); scaled forms
    localparam logic [31:0] RPM1_NUM  = 32'h0000_0006;
    localparam logic [31:0] RPM1_DEN  = 32'h0000_0005;
    localparam logic [31:0] RPM01_NUM = 32'h0000_000C;

endpackage

/* File: verilog/dsr_read_channel.sv */
// one read channel: request edge detect, capture on rising request, done flag
`timescale 1ns/1ps
module dsr_read_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        req,
    input  wire logic [15:0] value,
    output logic             done,
    output logic [15:0]      data
);

    typedef struct packed {
        logic        req_q;
        logic        done;
        logic [15:0] data;
    } dsr_chan_t;

    dsr_chan_t r;
    dsr_chan_t next_r;

    always_comb begin
        next_r       = r;
        next_r.req_q = req;
        if (req && !r.req_q && !r.done) begin
            next_r.data = value;
            next_r.done = 1'b1;
        end else if (!req) begin
            // done only drops with the request, so a held request never re-captures
            next_r.done = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{req_q: 1'b0, done: 1'b0, data: dsr_pkg::DATA_RST};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign done = r.done;
    assign data = r.data;

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (ce && req && !r.req_q && !r.done) |=> (r.done && r.data == $past(value));
    endproperty
    a_capture: assert property (p_capture) else $error("rising request did not capture");

    property p_done_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(r.done) |-> $past(req && !r.req_q && ce);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done rose without rising request");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (r.done && req && r.req_q) |=> $stable(r.data);
    endproperty
    a_hold: assert property (p_hold) else $error("readback changed while request held");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (ce && !req) |=> !r.done;
    endproperty
    a_clear: assert property (p_clear) else $error("done not cleared after request drop");

endmodule

/* File: verilog/dsr_unit_conv.sv */
// frequency setting to readback unit conversion, registered
`timescale 1ns/1ps
module dsr_unit_conv #(
    parameter int POLES = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic [1:0]  unit,
    input  wire logic [15:0] freq_in,
    output logic [15:0]      scaled
);

    typedef struct packed {
        logic [15:0] val;
    } dsr_conv_t;

    dsr_conv_t   r;
    dsr_conv_t   next_r;
    logic [31:0] wide;

    always_comb begin
        next_r = r;
        if (unit == dsr_pkg::UNIT_RPM1) begin
            wide = ({16'h0000, freq_in} * dsr_pkg::RPM1_NUM) / (dsr_pkg::RPM1_DEN * 32'(POLES));
        end else if (unit == dsr_pkg::UNIT_RPM01) begin
            wide = ({16'h0000, freq_in} * dsr_pkg::RPM01_NUM) / 32'(POLES);
        end else begin
            wide = {16'h0000, freq_in};
        end
        next_r.val = wide[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{val: dsr_pkg::DATA_RST};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign scaled = r.val;

    property p_hz_pass;
        @(posedge pclk) disable iff (!presetn)
        (ce && unit == dsr_pkg::UNIT_HZ) |=> (scaled == $past(freq_in));
    endproperty
    a_hz_pass: assert property (p_hz_pass) else $error("hz readback not passed through");

    property p_rpm01_scale;
        @(posedge pclk) disable iff (!presetn)
        (ce && unit == dsr_pkg::UNIT_RPM01)
            |=> (32'(scaled) == ((32'($past(freq_in)) * 32'd12) / 32'(POLES)) % 32'h0001_0000);
    endproperty
    a_rpm01_scale: assert property (p_rpm01_scale) else $error("0.1 rpm scaling wrong");

endmodule

/* File: verilog/dsr_readback.sv */
// drive setting readback: three request/done read channels behind an apb register slave
//
// Behaviour
// - readback captured when done rises, only after request goes off to on.
// - while request stays on, the readback register is not updated.
// - mode codes: 0 network control, 1 external terminal, 2 panel unit.
// - nonzero mode parameter reports its fixed mode; 3 or 4 report panel unit. The code forces only 3 and 4; other values report op_mode_live.
// - ram frequency readback is unsigned hundredths of a hertz.
// - eeprom frequency readback uses the same hundredths of a hertz scale.
// - in speed setting both frequency readbacks are 1 or 0.1 r/min.
// - frequency channels return the stored setting, never the terminal command.
// - three independent channels, each with request, done and readback, always usable.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module dsr_readback #(
    parameter int POLES = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // drive state feeding the channels
    input  wire logic [1:0]  op_mode_live,
    input  wire logic [15:0] ram_set_freq,
    input  wire logic [15:0] eeprom_set_freq,
    // done flags, also visible in the status register
    output logic             mode_read_done,
    output logic             ram_freq_read_done,
    output logic             eeprom_freq_read_done
);

    typedef struct packed {
        logic [2:0]  req;
        logic [1:0]  unit;
        logic [3:0]  msel;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dsr_top_t;

    dsr_top_t    r;
    dsr_top_t    next_r;

    logic        access;
    logic        hit;
    logic [31:0] rd;
    logic [15:0] mode_val;
    logic [15:0] ram_scaled;
    logic [15:0] eep_scaled;
    logic [2:0]  done;
    logic [15:0] mode_readback;
    logic [15:0] ram_freq_readback;
    logic [15:0] eeprom_freq_readback;

    // mode value presented to the mode channel
    always_comb begin
        if (r.msel == dsr_pkg::MSEL_PU_A || r.msel == dsr_pkg::MSEL_PU_B) begin
            mode_val = dsr_pkg::MODE_PU;
        end else if (op_mode_live == dsr_pkg::MODE_NET[1:0]) begin
            mode_val = dsr_pkg::MODE_NET;
        end else if (op_mode_live == dsr_pkg::MODE_PU[1:0]) begin
            mode_val = dsr_pkg::MODE_PU;
        end else begin
            // the live mode already follows a fixed parameter; unused code folds to external
            mode_val = dsr_pkg::MODE_EXT;
        end
    end

    // stored settings only; the terminal frequency command never enters this block
    dsr_unit_conv #(
        .POLES   (POLES)
    ) u_conv_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .unit    (r.unit),
        .freq_in (ram_set_freq),
        .scaled  (ram_scaled)
    );

    dsr_unit_conv #(
        .POLES   (POLES)
    ) u_conv_eep (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .unit    (r.unit),
        .freq_in (eeprom_set_freq),
        .scaled  (eep_scaled)
    );

    // one instance per channel, no shared state between them
    dsr_read_channel u_ch_mode (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .req     (r.req[dsr_pkg::CH_MODE]),
        .value   (mode_val),
        .done    (done[dsr_pkg::CH_MODE]),
        .data    (mode_readback)
    );

    dsr_read_channel u_ch_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .req     (r.req[dsr_pkg::CH_RAM]),
        .value   (ram_scaled),
        .done    (done[dsr_pkg::CH_RAM]),
        .data    (ram_freq_readback)
    );

    dsr_read_channel u_ch_eep (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .req     (r.req[dsr_pkg::CH_EEP]),
        .value   (eep_scaled),
        .done    (done[dsr_pkg::CH_EEP]),
        .data    (eeprom_freq_readback)
    );

    // read decode
    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        if (paddr == dsr_pkg::OFS_CTRL) begin
            rd[2:0] = r.req;
        end else if (paddr == dsr_pkg::OFS_STATUS) begin
            rd[2:0] = done;
        end else if (paddr == dsr_pkg::OFS_MODE) begin
            rd[15:0] = mode_readback;
        end else if (paddr == dsr_pkg::OFS_RAM_FREQ) begin
            rd[15:0] = ram_freq_readback;
        end else if (paddr == dsr_pkg::OFS_EEP_FREQ) begin
            rd[15:0] = eeprom_freq_readback;
        end else if (paddr == dsr_pkg::OFS_CFG) begin
            rd[dsr_pkg::CFG_UNIT_LSB +: 2] = r.unit;
            rd[dsr_pkg::CFG_MSEL_LSB +: 4] = r.msel;
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state keeps pready, pslverr and prdata straight from flip-flops
    always_comb begin
        access         = psel && penable;
        next_r         = r;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (access && !r.pready) begin
            next_r.pready  = 1'b1;
            next_r.pslverr = !hit;
            next_r.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
        if (access && r.pready && pwrite && !r.pslverr && pstrb[0]) begin
            if (paddr == dsr_pkg::OFS_CTRL) begin
                // software toggles these to re-arm a channel
                next_r.req = pwdata[2:0];
            end else if (paddr == dsr_pkg::OFS_CFG) begin
                next_r.unit = pwdata[dsr_pkg::CFG_UNIT_LSB +: 2];
                next_r.msel = pwdata[dsr_pkg::CFG_MSEL_LSB +: 4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{req:     dsr_pkg::CTRL_RST,
                   unit:    dsr_pkg::UNIT_RST,
                   msel:    dsr_pkg::MSEL_RST,
                   pready:  1'b0,
                   pslverr: 1'b0,
                   prdata:  32'h0000_0000};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign pready                = r.pready;
    assign pslverr               = r.pslverr;
    assign prdata                = r.prdata;
    assign mode_read_done        = done[dsr_pkg::CH_MODE];
    assign ram_freq_read_done    = done[dsr_pkg::CH_RAM];
    assign eeprom_freq_read_done = done[dsr_pkg::CH_EEP];

    property p_mode_pu;
        @(posedge pclk) disable iff (!presetn)
        (r.msel == dsr_pkg::MSEL_PU_A || r.msel == dsr_pkg::MSEL_PU_B) |-> (mode_val == dsr_pkg::MODE_PU);
    endproperty
    a_mode_pu: assert property (p_mode_pu) else $error("mode 3 or 4 not reported as panel unit");

    property p_mode_codes;
        @(posedge pclk) disable iff (!presetn)
        (mode_readback <= dsr_pkg::MODE_PU) && (mode_val <= dsr_pkg::MODE_PU);
    endproperty
    a_mode_codes: assert property (p_mode_codes) else $error("unused mode code reported");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready) |=> pready ##1 (!pready || !$past(ce));
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one wait state");

    property p_req_write;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && pready && pwrite && !pslverr && pstrb[0] && paddr == dsr_pkg::OFS_CTRL)
            |=> (r.req == $past(pwdata[2:0]));
    endproperty
    a_req_write: assert property (p_req_write) else $error("request write not applied");

    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !pwrite && paddr == dsr_pkg::OFS_STATUS)
            |=> (prdata == {29'h0, $past(done)});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read does not show done flags");

    property p_mode_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !pwrite && paddr == dsr_pkg::OFS_MODE)
            |=> (prdata == {16'h0000, $past(mode_readback)});
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback read wrong");

    property p_ram_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !pwrite && paddr == dsr_pkg::OFS_RAM_FREQ)
            |=> (prdata == {16'h0000, $past(ram_freq_readback)});
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("ram frequency readback read wrong");

    property p_eep_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !pwrite && paddr == dsr_pkg::OFS_EEP_FREQ)
            |=> (prdata == {16'h0000, $past(eeprom_freq_readback)});
    endproperty
    a_eep_read: assert property (p_eep_read) else $error("eeprom frequency readback read wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !hit) |=> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_write_zero;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && pwrite) |=> (prdata == 32'h0000_0000);
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write answer carries read data");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        !pready |-> !pslverr;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error flag outside answer cycle");

    property p_ce_freeze;
        @(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(r);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

    property p_ram_source;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.unit == dsr_pkg::UNIT_HZ) |=> (ram_scaled == $past(ram_set_freq));
    endproperty
    a_ram_source: assert property (p_ram_source) else $error("ram channel not fed stored setting");

    property p_eep_source;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.unit == dsr_pkg::UNIT_HZ) |=> (eep_scaled == $past(eeprom_set_freq));
    endproperty
    a_eep_source: assert property (p_eep_source) else $error("eeprom channel not fed stored setting");

    property p_mode_net;
        @(posedge pclk) disable iff (!presetn)
        (r.msel != dsr_pkg::MSEL_PU_A && r.msel != dsr_pkg::MSEL_PU_B && op_mode_live == dsr_pkg::MODE_NET[1:0])
            |-> (mode_val == dsr_pkg::MODE_NET);
    endproperty
    a_mode_net: assert property (p_mode_net) else $error("network mode not reported");

    property p_mode_ext;
        @(posedge pclk) disable iff (!presetn)
        (r.msel != dsr_pkg::MSEL_PU_A && r.msel != dsr_pkg::MSEL_PU_B
            && (op_mode_live == dsr_pkg::MODE_EXT[1:0] || op_mode_live == 2'h3)) |-> (mode_val == dsr_pkg::MODE_EXT);
    endproperty
    a_mode_ext: assert property (p_mode_ext) else $error("external mode not reported");

    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && pready && pwrite && !pslverr && pstrb[0] && paddr == dsr_pkg::OFS_CFG)
            |=> (r.unit == $past(pwdata[dsr_pkg::CFG_UNIT_LSB +: 2])
                 && r.msel == $past(pwdata[dsr_pkg::CFG_MSEL_LSB +: 4]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not applied");

    property p_ro_write;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && pready && pwrite && paddr != dsr_pkg::OFS_CTRL)
            |=> (r.req == $past(r.req));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("requests changed by write elsewhere");

endmodule

/* File: dv/dsr_drive_model.sv */
// partner model: drive state source feeding the three readback channels
`timescale 1ns/1ps
module dsr_drive_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [1:0]  mode_set,
    input  wire logic [15:0] ram_set,
    input  wire logic [15:0] eep_set,
    output logic [1:0]       op_mode_live,
    output logic [15:0]      ram_set_freq,
    output logic [15:0]      eeprom_set_freq
);
    // stored settings move only on the clock, like the drive's own registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode_live    <= 2'h0;
            ram_set_freq    <= 16'h0000;
            eeprom_set_freq <= 16'h0000;
        end else begin
            op_mode_live    <= mode_set;
            ram_set_freq    <= ram_set;
            eeprom_set_freq <= eep_set;
        end
    end
endmodule

/* File: dv/dsr_readback_tb_top.sv */
// self-checking testbench of the drive setting readback block
`timescale 1ns/1ps
module dsr_readback_tb_top;
    localparam int POLES = 4;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, ex;
    logic [3:0]  pstrb, ms;
    logic [1:0]  op_mode_live, mode_set;
    logic [15:0] ram_set_freq, eeprom_set_freq, ram_set, eep_set;
    logic        md, rdn, edn;
    int          failures, n_checks, cycles;

    dsr_drive_model u_drv (.pclk(pclk), .presetn(presetn), .mode_set(mode_set), .ram_set(ram_set),
        .eep_set(eep_set), .op_mode_live(op_mode_live), .ram_set_freq(ram_set_freq),
        .eeprom_set_freq(eeprom_set_freq));
    dsr_readback #(.POLES(POLES)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .op_mode_live(op_mode_live),
        .ram_set_freq(ram_set_freq), .eeprom_set_freq(eeprom_set_freq), .mode_read_done(md),
        .ram_freq_read_done(rdn), .eeprom_freq_read_done(edn));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // a hung design must still reach the verdict
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // starts just after a rising edge; pready and the answer are taken at the rising edge,
    // then one idle cycle so no strobe is assigned twice in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", 32'h1, {31'h0, pready});
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    task automatic req(input logic [2:0] m);
        apb(1'b1, dsr_pkg::OFS_CTRL, {29'h0, m});
    endtask

    task automatic done_chk(input logic [2:0] exp);
        @(posedge pclk);
        chk("done pins", {29'h0, exp}, {29'h0, edn, rdn, md});
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, mode_set, ram_set, eep_set} = '0;
        pstrb   = 4'hF;
        ce      = 1'b1;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'h0, "reset value");
        apb(1'b1, dsr_pkg::OFS_STATUS, 32'h0000_0007);
        chk("read only write error", 32'h0, {31'h0, err});
        chk("write answer data", 32'h0, rd);
        rd_chk(dsr_pkg::OFS_STATUS, 32'h0, "status read only");
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, {31'h0, err});
        // every live mode, selection parameter at zero
        for (int m = 0; m < 4; m++) begin
            mode_set <= 2'(m);
            ex = (m == 0) ? dsr_pkg::MODE_NET : (m == 2) ? dsr_pkg::MODE_PU : dsr_pkg::MODE_EXT;
            req(3'h1);
            done_chk(3'h1);
            rd_chk(dsr_pkg::OFS_MODE, ex, "mode code");
            req(3'h0);
            done_chk(3'h0);
        end
        // fixed selections 3 and 4 override the live mode; selection 1 reports it
        mode_set <= 2'h1;
        for (int i = 0; i < 3; i++) begin
            ms = (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : 4'h4;
            apb(1'b1, dsr_pkg::OFS_CFG, {24'h0, ms, 4'h0});
            req(3'h1);
            ex = (i == 0) ? dsr_pkg::MODE_EXT : dsr_pkg::MODE_PU;
            rd_chk(dsr_pkg::OFS_MODE, ex, "fixed mode");
            req(3'h0);
        end
        apb(1'b1, dsr_pkg::OFS_CFG, 32'h0);
        ram_set <= 16'd6000;
        eep_set <= 16'd1234;
        req(3'h6);
        done_chk(3'h6);
        rd_chk(dsr_pkg::OFS_STATUS, 32'h6, "status flags");
        rd_chk(dsr_pkg::OFS_CTRL, 32'h6, "ctrl readback");
        rd_chk(dsr_pkg::OFS_RAM_FREQ, 32'd6000, "ram freq");
        rd_chk(dsr_pkg::OFS_EEP_FREQ, 32'd1234, "eeprom freq");
        ram_set <= 16'd100;
        req(3'h6);
        rd_chk(dsr_pkg::OFS_RAM_FREQ, 32'd6000, "held request");
        req(3'h0);
        req(3'h2);
        rd_chk(dsr_pkg::OFS_RAM_FREQ, 32'd100, "refreshed ram");
        req(3'h0);
        // speed units: whole and tenth r/min
        ram_set <= 16'd6000;
        for (int u = 1; u < 3; u++) begin
            apb(1'b1, dsr_pkg::OFS_CFG, 32'(u));
            req(3'h6);
            ex = (u == 1) ? 32'(6000 * 6 / (5 * POLES)) : 32'(6000 * 12 / POLES);
            rd_chk(dsr_pkg::OFS_RAM_FREQ, ex, "ram speed");
            ex = (u == 1) ? 32'(1234 * 6 / (5 * POLES)) : 32'(1234 * 12 / POLES);
            rd_chk(dsr_pkg::OFS_EEP_FREQ, ex, "eeprom speed");
            req(3'h0);
        end
        final_report();
    end
endmodule
